// [shared/vphy_special_pkg.sv]
// constants, field layout and carrier types of the virtual phy special control register
package vphy_special_pkg;
    // location in the system map (byte address) and on the serial management bus (index)
    localparam logic [15:0] SPECIAL_CTRL_OFFSET = 16'h01dc;
    localparam logic [4:0]  SPECIAL_CTRL_INDEX  = 5'h1f;
    // field positions inside the sixteen visible bits
    localparam int MODE2_BIT    = 15;
    localparam int LOOPBACK_BIT = 14;
    localparam int MODE_HI_BIT  = 9;
    localparam int MODE_LO_BIT  = 8;
    localparam int COLL_BIT     = 7;
    localparam int CLK_DIR_BIT  = 6;
    localparam int CLK_STR_BIT  = 5;
    // port mode codes
    localparam logic [2:0] MODE_RMII_MAC = 3'h2;
    localparam logic [2:0] MODE_RMII_PHY = 3'h3;
    // reset values and padding
    localparam logic        CTRL_BIT_RESET = 1'b0;
    localparam logic [15:0] PAD_ZERO       = 16'h0000;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    // hardware straps that seed the read-only and kept-over-soft-reset fields
    typedef struct packed {
        logic [2:0] mode;
        logic       clk_dir;
        logic       clk_str;
    } strap_type;

    // one rmii transmit symbol
    typedef struct packed {
        logic       en;
        logic [1:0] data;
    } rmii_sym_type;

    localparam rmii_sym_type SYM_IDLE = '0;
    localparam strap_type    STRAP_ZERO = '0;

    // strap capture sequencing, gray along load -> run
    typedef enum logic [1:0] {
        ST_LOAD = 2'h0,
        ST_RUN  = 2'h1
    } strap_state_type;
endpackage

// [logic/virtual_phy_special_ctrl.sv]
// virtual phy special control/status register with loopback, collision test and clock control
`timescale 1ns/1ps
module virtual_phy_special_ctrl (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst_n,
    input  wire logic                           i_vphy_soft_rst,
    input  wire logic                           i_vphy_reset_control,
    input  wire vphy_special_pkg::strap_type    i_straps,
    input  wire logic [15:0]                    i_sys_addr,
    input  wire logic                           i_sys_wr,
    input  wire logic                           i_sys_rd,
    input  wire logic [31:0]                    i_sys_wdata,
    output logic      [31:0]                    o_sys_rdata,
    output logic                                o_sys_rvalid,
    input  wire logic [4:0]                     i_mdio_reg,
    input  wire logic                           i_mdio_wr,
    input  wire logic                           i_mdio_rd,
    input  wire logic [15:0]                    i_mdio_wdata,
    output logic      [15:0]                    o_mdio_rdata,
    output logic                                o_mdio_rvalid,
    input  wire logic                           i_isolate,
    input  wire vphy_special_pkg::rmii_sym_type i_fab_tx,
    input  wire logic                           i_swe_tx_active,
    output vphy_special_pkg::rmii_sym_type      o_ext_tx,
    output vphy_special_pkg::rmii_sym_type      o_swe_loop_rx,
    output logic                                o_fab_col,
    output logic                                o_refclk_oe_n,
    output logic                                o_clk_drive_16ma,
    output logic      [2:0]                     o_port_mode,
    output logic                                o_loopback
);

    vphy_special_pkg::strap_type       strap_s1_r;
    vphy_special_pkg::strap_type       strap_s2_r;
    vphy_special_pkg::strap_type       strap_s3_r;
    logic                              fill_s1_r;
    logic                              fill_s2_r;
    logic                              fill_s3_r;
    vphy_special_pkg::strap_state_type state_r;
    logic [2:0]                        mode_r;
    logic                              loop_r;
    logic                              coll_r;
    logic                              clk_dir_r;
    logic                              clk_str_r;
    logic                              sys_wr_hit;
    logic                              mdio_wr_hit;
    logic                              wr_hit;
    logic [15:0]                       wr_word;
    logic                              strap_take;
    logic                              hard_rst;
    logic                              soft_rst;

    // assemble the visible sixteen bits; used by both read paths
    function automatic logic [15:0] pack_word(input logic [2:0] mode, input logic lb,
                                              input logic col, input logic dir, input logic str);
        logic [15:0] w;
        w = vphy_special_pkg::WORD_ZERO;
        w[vphy_special_pkg::MODE2_BIT]    = mode[2];
        w[vphy_special_pkg::MODE_HI_BIT]  = mode[1];
        w[vphy_special_pkg::MODE_LO_BIT]  = mode[0];
        w[vphy_special_pkg::LOOPBACK_BIT] = lb;
        w[vphy_special_pkg::COLL_BIT]     = col;
        w[vphy_special_pkg::CLK_DIR_BIT]  = dir;
        w[vphy_special_pkg::CLK_STR_BIT]  = str;
        return w;
    endfunction

    // write decode; system map wins if both ports write in one cycle
    assign sys_wr_hit  = i_sys_wr && (i_sys_addr == vphy_special_pkg::SPECIAL_CTRL_OFFSET);
    assign mdio_wr_hit = i_mdio_wr && (i_mdio_reg == vphy_special_pkg::SPECIAL_CTRL_INDEX);
    assign wr_hit      = sys_wr_hit || mdio_wr_hit;
    assign wr_word     = sys_wr_hit ? i_sys_wdata[15:0] : i_mdio_wdata;
    assign hard_rst    = !i_rst_n || i_vphy_reset_control;
    assign soft_rst    = hard_rst || i_vphy_soft_rst;
    // a strap counts once the second and third stages agree; the fill flags keep a
    // freshly reset chain, whose stages all read zero, from passing for agreement
    assign strap_take  = (state_r == vphy_special_pkg::ST_LOAD) && fill_s3_r
                         && (strap_s2_r == strap_s3_r);

    // strap synchroniser, three stages
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            strap_s1_r <= vphy_special_pkg::STRAP_ZERO;
            strap_s2_r <= vphy_special_pkg::STRAP_ZERO;
            strap_s3_r <= vphy_special_pkg::STRAP_ZERO;
            fill_s1_r  <= 1'b0;
            fill_s2_r  <= 1'b0;
            fill_s3_r  <= 1'b0;
        end else begin
            strap_s1_r <= i_straps;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            fill_s1_r  <= 1'b1;
            fill_s2_r  <= fill_s1_r;
            fill_s3_r  <= fill_s2_r;
        end
    end

    // capture straps after each hard reset; reset itself only loads constants
    always_ff @(posedge i_clk_sys) begin
        if (hard_rst) begin
            state_r <= vphy_special_pkg::ST_LOAD;
        end else begin
            case (state_r)
                vphy_special_pkg::ST_LOAD: begin
                    if (strap_take) begin
                        state_r <= vphy_special_pkg::ST_RUN;
                    end
                end
                vphy_special_pkg::ST_RUN: begin
                    state_r <= vphy_special_pkg::ST_RUN;
                end
                default: begin
                    state_r <= vphy_special_pkg::ST_LOAD;
                end
            endcase
        end
    end

    // port mode, read-only, seeded from straps
    always_ff @(posedge i_clk_sys) begin
        if (hard_rst) begin
            mode_r <= vphy_special_pkg::STRAP_ZERO.mode;
        end else if (strap_take) begin
            mode_r <= strap_s3_r.mode;
        end
    end

    // clock bits: kept over soft reset, only hard resets reload them
    always_ff @(posedge i_clk_sys) begin
        if (hard_rst) begin
            clk_dir_r <= vphy_special_pkg::CTRL_BIT_RESET;
            clk_str_r <= vphy_special_pkg::CTRL_BIT_RESET;
        end else if (strap_take) begin
            clk_dir_r <= strap_s3_r.clk_dir;
            clk_str_r <= strap_s3_r.clk_str;
        end else if (wr_hit) begin
            clk_dir_r <= wr_word[vphy_special_pkg::CLK_DIR_BIT];
            clk_str_r <= wr_word[vphy_special_pkg::CLK_STR_BIT];
        end
    end

    // loopback and collision test; cleared by any reset, soft reset beats a write
    always_ff @(posedge i_clk_sys) begin
        if (soft_rst) begin
            loop_r <= vphy_special_pkg::CTRL_BIT_RESET;
            coll_r <= vphy_special_pkg::CTRL_BIT_RESET;
        end else if (wr_hit) begin
            loop_r <= wr_word[vphy_special_pkg::LOOPBACK_BIT];
            coll_r <= wr_word[vphy_special_pkg::COLL_BIT];
        end
    end

    // read paths, one cycle; unmapped reads answer zero
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sys_rdata   <= {vphy_special_pkg::PAD_ZERO, vphy_special_pkg::WORD_ZERO};
            o_sys_rvalid  <= 1'b0;
            o_mdio_rdata  <= vphy_special_pkg::WORD_ZERO;
            o_mdio_rvalid <= 1'b0;
        end else begin
            o_sys_rvalid  <= i_sys_rd;
            o_mdio_rvalid <= i_mdio_rd;
            if (i_sys_rd && (i_sys_addr == vphy_special_pkg::SPECIAL_CTRL_OFFSET)) begin
                o_sys_rdata <= {vphy_special_pkg::PAD_ZERO,
                                pack_word(mode_r, loop_r, coll_r, clk_dir_r, clk_str_r)};
            end else begin
                o_sys_rdata <= {vphy_special_pkg::PAD_ZERO, vphy_special_pkg::WORD_ZERO};
            end
            if (i_mdio_rd && (i_mdio_reg == vphy_special_pkg::SPECIAL_CTRL_INDEX)) begin
                o_mdio_rdata <= pack_word(mode_r, loop_r, coll_r, clk_dir_r, clk_str_r);
            end else begin
                o_mdio_rdata <= vphy_special_pkg::WORD_ZERO;
            end
        end
    end

    // transmit steering; isolate blocks the pin side only, so loopback still runs
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_ext_tx      <= vphy_special_pkg::SYM_IDLE;
            o_swe_loop_rx <= vphy_special_pkg::SYM_IDLE;
        end else begin
            o_ext_tx      <= (loop_r || i_isolate) ? vphy_special_pkg::SYM_IDLE
                                                   : i_fab_tx;
            o_swe_loop_rx <= loop_r ? i_fab_tx : vphy_special_pkg::SYM_IDLE;
        end
    end

    // collision forcing and pad controls
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_fab_col        <= 1'b0;
            o_refclk_oe_n    <= 1'b1;
            o_clk_drive_16ma <= 1'b0;
            o_port_mode      <= vphy_special_pkg::STRAP_ZERO.mode;
            o_loopback       <= 1'b0;
        end else begin
            o_fab_col        <= coll_r && i_swe_tx_active;
            o_refclk_oe_n    <= !clk_dir_r;
            o_clk_drive_16ma <= clk_str_r;
            o_port_mode      <= mode_r;
            o_loopback       <= loop_r;
        end
    end

    a_loop_blocks_ext: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        loop_r |=> (o_ext_tx == vphy_special_pkg::SYM_IDLE))
        else $error("external port sees traffic during loopback");

    a_loop_iso_feed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (loop_r && i_isolate) |=> (o_swe_loop_rx == $past(i_fab_tx)))
        else $error("loopback lost while isolated");

    a_mode_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sys_rd && i_sys_addr == vphy_special_pkg::SPECIAL_CTRL_OFFSET)
        |=> ({o_sys_rdata[15], o_sys_rdata[9:8]} == $past(mode_r)))
        else $error("mode field read back wrong");

    a_coll_follows_tx: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_fab_col == ($past(coll_r) && $past(i_swe_tx_active))))
        else $error("collision indication wrong");

    a_refclk_dir_pin: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(clk_dir_r) |=> !o_refclk_oe_n)
        else $error("reference clock pin not driven");

    a_clk_strength_pin: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (clk_str_r ##1 clk_str_r) |-> o_clk_drive_16ma)
        else $error("drive strength select wrong");

    a_strap_seed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (strap_take && !i_vphy_reset_control)
        |=> (mode_r == $past(strap_s3_r.mode)) && (clk_dir_r == $past(strap_s3_r.clk_dir)))
        else $error("strap defaults not loaded");

    a_kept_over_soft: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_vphy_soft_rst && !i_vphy_reset_control && !wr_hit && !strap_take)
        |=> $stable(clk_dir_r) && $stable(clk_str_r) && !loop_r && !coll_r)
        else $error("soft reset disturbed kept bits");

    a_upper_pad_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sys_rd |=> (o_sys_rdata[31:16] == vphy_special_pkg::PAD_ZERO))
        else $error("padding bits not zero");

    a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_mdio_rd |=> (o_mdio_rdata[13:10] == 4'h0) && (o_mdio_rdata[4:0] == 5'h00))
        else $error("reserved bits not zero");

endmodule // virtual_phy_special_ctrl

// [test/rmii_far_end.sv]
// far-end rmii device model that takes symbols from the external transmit port
`timescale 1ns/1ps
module rmii_far_end (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst_n,
    input  wire vphy_special_pkg::rmii_sym_type i_rx_sym,
    output logic      [15:0]                    o_sym_count,
    output vphy_special_pkg::rmii_sym_type      o_last_sym
);
    // only symbols with enable high carry data; the count shows any leak past loopback
    // receive-own-transmit setup of the port receive config is outside this model
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sym_count <= 16'h0000;
            o_last_sym  <= vphy_special_pkg::SYM_IDLE;
        end else if (i_rx_sym.en === 1'b1) begin
            o_sym_count <= o_sym_count + 16'h0001;
            o_last_sym  <= i_rx_sym;
        end
    end
endmodule // rmii_far_end

// [test/test_virtual_phy_special_ctrl.sv]
// self-checking testbench of the virtual phy special control register
`timescale 1ns/1ps
module test_virtual_phy_special_ctrl;
    logic clk_sys, rst_n, soft_rst, reset_control, sys_wr, sys_rd, sys_rvalid, mdio_wr, mdio_rd;
    logic mdio_rvalid, isolate, swe_tx_active, fab_col, refclk_oe_n, clk_drive_16ma, loopback;
    logic [15:0] sys_addr, mdio_wdata, mdio_rdata, sym_count, base;
    logic [31:0] sys_wdata, sys_rdata;
    logic [4:0]  mdio_reg;
    logic [2:0]  port_mode;
    vphy_special_pkg::strap_type    straps;
    vphy_special_pkg::rmii_sym_type fab_tx, ext_tx, swe_loop_rx, last_sym;
    int n_errors, n_compared, cycles;
    localparam logic [15:0] REG_OFS = vphy_special_pkg::SPECIAL_CTRL_OFFSET;

    virtual_phy_special_ctrl dut_u (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .i_vphy_soft_rst(soft_rst), .i_vphy_reset_control(reset_control), .i_straps(straps),
        .i_sys_addr(sys_addr), .i_sys_wr(sys_wr), .i_sys_rd(sys_rd), .i_sys_wdata(sys_wdata),
        .o_sys_rdata(sys_rdata), .o_sys_rvalid(sys_rvalid), .i_mdio_reg(mdio_reg),
        .i_mdio_wr(mdio_wr), .i_mdio_rd(mdio_rd), .i_mdio_wdata(mdio_wdata),
        .o_mdio_rdata(mdio_rdata), .o_mdio_rvalid(mdio_rvalid), .i_isolate(isolate),
        .i_fab_tx(fab_tx), .i_swe_tx_active(swe_tx_active), .o_ext_tx(ext_tx),
        .o_swe_loop_rx(swe_loop_rx), .o_fab_col(fab_col), .o_refclk_oe_n(refclk_oe_n),
        .o_clk_drive_16ma(clk_drive_16ma), .o_port_mode(port_mode), .o_loopback(loopback));
    rmii_far_end far_u (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_rx_sym(ext_tx),
        .o_sym_count(sym_count), .o_last_sym(last_sym));

    // 200 MHz clock; the cycle ceiling cuts a hung handshake short
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // expected sixteen visible bits; everything unnamed reads zero
    function automatic logic [15:0] exp_reg(input logic [2:0] m, input logic l, c, d, s);
        return {m[2], l, 4'h0, m[1:0], c, d, s, 5'h00};
    endfunction

    // one-cycle strobes; read answer is looked at in the cycle it stands
    task automatic sys_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sys_addr  <= a;
        sys_wdata <= d;
        sys_wr    <= 1'b1;
        @(posedge clk_sys);
        sys_wr <= 1'b0;
    endtask
    task automatic sys_read(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        sys_addr <= a;
        sys_rd   <= 1'b1;
        @(posedge clk_sys);
        sys_rd <= 1'b0;
        #1;
        check("sys rvalid", {31'h0, sys_rvalid}, 32'h1);
        check("sys rdata", sys_rdata, e);
    endtask
    task automatic mdio_access(input logic wr, input logic [15:0] d);
        @(posedge clk_sys);
        mdio_wdata <= d;
        mdio_wr    <= wr;
        mdio_rd    <= ~wr;
        @(posedge clk_sys);
        mdio_wr <= 1'b0;
        mdio_rd <= 1'b0;
        #1;
        if (!wr) check("mdio rdata", {15'h0, mdio_rvalid, mdio_rdata}, {15'h1, d});
    endtask

    task automatic t_defaults();
        repeat (8) @(posedge clk_sys);
        #1;
        check("port mode", port_mode, vphy_special_pkg::MODE_RMII_MAC);
        check("refclk oe_n", refclk_oe_n, 1'b0);
        check("drive 16ma", clk_drive_16ma, 1'b0);
        sys_read(REG_OFS, {16'h0, exp_reg(3'h2, 0, 0, 1, 0)});
        mdio_access(1'b0, exp_reg(3'h2, 0, 0, 1, 0));
    endtask
    task automatic t_masks();
        sys_write(REG_OFS, 32'hffff_ff9f);
        sys_read(REG_OFS, {16'h0, exp_reg(3'h2, 1, 1, 0, 0)});
        check("refclk oe_n", refclk_oe_n, 1'b1);
        mdio_access(1'b1, 16'hffa0);
        mdio_access(1'b0, exp_reg(3'h2, 1, 1, 0, 1));
        check("drive 16ma", clk_drive_16ma, 1'b1);
        sys_write(16'h01d8, 32'h0000_0000);
        sys_read(16'h01d8, 32'h0);
        // another serial index must neither take the write nor answer with the register
        @(posedge clk_sys);
        mdio_reg <= 5'h06;
        mdio_access(1'b1, 16'h0000);
        mdio_access(1'b0, 16'h0000);
        @(posedge clk_sys);
        mdio_reg <= vphy_special_pkg::SPECIAL_CTRL_INDEX;
        mdio_access(1'b0, exp_reg(3'h2, 1, 1, 0, 1));
    endtask
    // isolate held high too: the loop must still work and nothing may leak out
    task automatic t_loopback();
        base = sym_count;
        sys_write(REG_OFS, 32'h0000_40a0);
        isolate       <= 1'b1;
        fab_tx        <= 3'h6;
        swe_tx_active <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check("loopback out", loopback, 1'b1);
        check("loop rx", swe_loop_rx, 3'h6);
        check("ext tx", ext_tx, vphy_special_pkg::SYM_IDLE);
        check("far count", sym_count, base);
        check("fab col", fab_col, 1'b1);
        swe_tx_active <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("fab col", fab_col, 1'b0);
    endtask
    task automatic t_normal();
        sys_write(REG_OFS, 32'h0000_0020);
        isolate <= 1'b0;
        fab_tx  <= 3'h5;
        repeat (3) @(posedge clk_sys);
        #1;
        check("loopback out", loopback, 1'b0);
        check("ext tx", ext_tx, 3'h5);
        check("loop rx", swe_loop_rx, vphy_special_pkg::SYM_IDLE);
        check("far last", last_sym, 3'h5);
    endtask
    // soft reset keeps clock bits; reset control reloads them and the mode from straps
    task automatic t_resets();
        sys_write(REG_OFS, 32'h0000_40e0);
        soft_rst <= 1'b1;
        @(posedge clk_sys);
        soft_rst <= 1'b0;
        sys_read(REG_OFS, {16'h0, exp_reg(3'h2, 0, 0, 1, 1)});
        // new straps must cross the synchroniser before the reload is asked for
        @(posedge clk_sys);
        straps    <= '{mode: 3'h3, clk_dir: 1'b0, clk_str: 1'b0};
        repeat (4) @(posedge clk_sys);
        reset_control <= 1'b1;
        @(posedge clk_sys);
        reset_control <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sys_read(REG_OFS, {16'h0, exp_reg(3'h3, 0, 0, 0, 0)});
        check("port mode", port_mode, vphy_special_pkg::MODE_RMII_PHY);
        check("refclk oe_n", refclk_oe_n, 1'b1);
    endtask

    // inputs set at time zero, then reset held for ten cycles
    initial begin
        {rst_n, soft_rst, reset_control, sys_wr, sys_rd, mdio_wr, mdio_rd} = '0;
        {isolate, swe_tx_active, sys_addr, sys_wdata, mdio_wdata} = '0;
        mdio_reg = vphy_special_pkg::SPECIAL_CTRL_INDEX;
        straps   = '{mode: 3'h2, clk_dir: 1'b1, clk_str: 1'b0};
        fab_tx   = vphy_special_pkg::SYM_IDLE;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults();
        t_masks();
        t_loopback();
        t_normal();
        t_resets();
        report_and_stop();
    end
endmodule // test_virtual_phy_special_ctrl
